// *** core/sfepe_pkg.sv ***
// Shared constants and types for the flash erase/program engine.
// Assumes a 40 MHz system clock and a 32 MB array of 64 KB blocks.
`default_nettype none

package sfepe_pkg;

  localparam int          CLK_MHZ        = 40;
  localparam int          ADDR_W         = 25;
  localparam int          BLK_W          = 9;
  localparam int          NUM_BLOCKS     = 512;
  localparam int          PAGE_BYTES     = 256;
  localparam int          HALF_BLK_LSB   = 15;
  localparam int          FULL_BLK_LSB   = 16;
  localparam int          PAGE_LSB       = 8;
  localparam logic [3:0]  BP_ALL_LIMIT   = 4'hA;

  // Opcodes of the handled commands
  localparam logic [7:0]  write_enable_cmd     = 8'h06;
  localparam logic [7:0]  half_block_erase_cmd = 8'h52;
  localparam logic [7:0]  full_block_erase_cmd = 8'hD8;
  localparam logic [7:0]  array_erase_cmd      = 8'h60;
  localparam logic [7:0]  array_erase_alt_cmd  = 8'hC7;
  localparam logic [7:0]  page_write_cmd       = 8'h02;

  // Address bytes in the two address modes
  localparam logic [2:0]  ADDR_BYTES_NARROW = 3'h3;
  localparam logic [2:0]  ADDR_BYTES_WIDE   = 3'h4;

  // Self-timed cycle lengths in microseconds
  localparam int          HALF_BLOCK_ERASE_TIME_US = 200;
  localparam int          FULL_BLOCK_ERASE_TIME_US = 400;
  localparam int          ARRAY_ERASE_TIME_US      = 2000;
  localparam int          PAGE_WRITE_TIME_US       = 50;

  typedef enum logic [2:0] {
    SFEPE_PH_OPC   = 3'b000,
    SFEPE_PH_ADDR  = 3'b001,
    SFEPE_PH_DATA  = 3'b010,
    SFEPE_PH_NOARG = 3'b011,
    SFEPE_PH_IGN   = 3'b100
  } sfepe_phase_t;

  typedef enum logic [2:0] {
    SFEPE_ST_IDLE  = 3'b000,
    SFEPE_ST_CHECK = 3'b001,
    SFEPE_ST_SCAN  = 3'b010,
    SFEPE_ST_PROG  = 3'b011,
    SFEPE_ST_TIME  = 3'b100
  } sfepe_state_t;

  typedef enum logic [1:0] {
    SFEPE_OP_HALF = 2'b00,
    SFEPE_OP_FULL = 2'b01,
    SFEPE_OP_CHIP = 2'b10,
    SFEPE_OP_PAGE = 2'b11
  } sfepe_op_t;

endpackage : sfepe_pkg

`default_nettype wire

// *** core/sfepe_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to clk; clk_en freezes it.
`default_nettype none

module sfepe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else if (clk_en) begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : sfepe_sync

`default_nettype wire

// *** core/sfepe_page_buf.sv ***
// Page data buffer: one byte per page offset plus a written mask.
// Assumes writes and reads come from the engine on the same clock.
`default_nettype none

module sfepe_page_buf
  import sfepe_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       clr,
  input  wire logic       we,
  input  wire logic [7:0] widx,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] ridx,
  output logic      [7:0] rdata,
  output logic            rvalid
);

  logic [7:0]            mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] written;

  always_ff @(posedge clk) begin
    if (clk_en && we) begin
      mem[widx] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      written <= '0;
    end else if (clk_en) begin
      if (clr) begin
        written <= '0;
      end else if (we) begin
        written[widx] <= 1'b1;
      end
    end
  end

  assign rdata  = mem[ridx];
  assign rvalid = written[ridx];

endmodule : sfepe_page_buf

`default_nettype wire

// *** core/sfepe_engine.sv ***
// Erase and page program command engine of a serial NOR flash.
// Assumes serial pins arrive asynchronously and mode/protect inputs are
// on clk; lock_hit answers lock_addr in the same cycle.
// Function
// - Half block erase clears addressed 32KB block
// - Full block erase clears addressed 64KB block
// - Array erase takes opcode only, erases all
// - Block erase is opcode, address, nothing more
// - Block erase chip-select rises after address
// - Array erase chip-select rises after opcode
// - Single-line or four-line opcode; ignore upper lines
// - Three-byte address default; wide mode extends
// - Internal cycle starts on chip-select rise
// - Status stays readable during internal cycle
// - Busy throughout cycle; end clears busy, latch
// - Protected blocks and pages are never changed
// - Scheme zero: array erase needs zero protect
// - Scheme one: array erase skips locked blocks
// - Program only clears bits, last 256 bytes
// - Program address wraps within the page
// - Over 256 bytes keeps only the last
// - Up to 256 bytes leave others untouched
// - Program needs data, rise on byte boundary
`default_nettype none

module sfepe_engine
  import sfepe_pkg::*;
#(
  parameter int HALF_TIME_US  = HALF_BLOCK_ERASE_TIME_US,
  parameter int FULL_TIME_US  = FULL_BLOCK_ERASE_TIME_US,
  parameter int ARRAY_TIME_US = ARRAY_ERASE_TIME_US,
  parameter int PAGE_TIME_US  = PAGE_WRITE_TIME_US
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              cs_n_pin,
  input  wire logic              sclk_pin,
  input  wire logic [3:0]        sio_pin,
  input  wire logic              four_line_command_mode,
  input  wire logic              wide_address_mode,
  input  wire logic              extended_address_bit,
  input  wire logic              protect_scheme_select,
  input  wire logic [3:0]        block_protect_field,
  input  wire logic              lock_hit,
  output logic                   busy_flag,
  output logic                   write_enable_latch,
  output logic [BLK_W-1:0]       lock_addr,
  output logic                   erase_stb,
  output logic [ADDR_W-1:0]      erase_addr,
  output logic [1:0]             erase_size,
  output logic                   prog_stb,
  output logic [ADDR_W-1:0]      prog_addr,
  output logic [7:0]             prog_data
);

  localparam logic [31:0] HALF_CYC  = 32'(HALF_TIME_US * CLK_MHZ);
  localparam logic [31:0] FULL_CYC  = 32'(FULL_TIME_US * CLK_MHZ);
  localparam logic [31:0] ARRAY_CYC = 32'(ARRAY_TIME_US * CLK_MHZ);
  localparam logic [31:0] PAGE_CYC  = 32'(PAGE_TIME_US * CLK_MHZ);
  localparam logic [BLK_W-1:0] LAST_BLK = BLK_W'(NUM_BLOCKS - 1);

  typedef struct packed {
    logic              prev_sclk;
    logic              prev_cs;
    sfepe_phase_t      phase;
    logic [2:0]        bitcnt;
    logic [7:0]        sh8;
    logic [7:0]        opcode;
    logic [2:0]        abytes;
    logic [31:0]       ashift;
    logic [7:0]        widx;
    logic              have_data;
    logic              latch;
    logic              busy;
    sfepe_state_t      st;
    sfepe_op_t         op;
    logic [ADDR_W-1:0] taddr;
    logic [7:0]        pidx;
    logic [31:0]       timer;
    logic [BLK_W-1:0]  lock_addr;
    logic              erase_stb;
    logic [ADDR_W-1:0] erase_addr;
    logic [1:0]        erase_size;
    logic              prog_stb;
    logic [ADDR_W-1:0] prog_addr;
    logic [7:0]        prog_data;
    logic              buf_clr;
    logic              buf_we;
    logic [7:0]        buf_widx;
    logic [7:0]        buf_wdata;
  } sfepe_engine_t;

  sfepe_engine_t s;
  sfepe_engine_t next_s;

  logic       sy_cs;
  logic       sy_sclk;
  logic [3:0] sy_sio;
  logic [7:0] buf_rdata;
  logic       buf_rvalid;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and page buffer

  sfepe_sync #(
    .W (6)
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      ({~cs_n_pin, sclk_pin, sio_pin}),  // Select inverted: reset reads as idle
    .q      ({sy_cs, sy_sclk, sy_sio})
  );

  sfepe_page_buf u_buf (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clr    (s.buf_clr),
    .we     (s.buf_we),
    .widx   (s.buf_widx),
    .wdata  (s.buf_wdata),
    .ridx   (s.pidx),
    .rdata  (buf_rdata),
    .rvalid (buf_rvalid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Protection decode for the block-protect scheme

  function automatic logic bp_protects(input logic [BLK_W-1:0] blk,
                                       input logic [3:0]       bp);
    logic [BLK_W:0] span;
    span = '0;
    if (bp == 4'h0) begin
      return 1'b0;
    end
    if (bp >= BP_ALL_LIMIT) begin
      return 1'b1;
    end
    span = (BLK_W+1)'(1) << (bp - 4'h1);
    return {1'b0, blk} >= ((BLK_W+1)'(NUM_BLOCKS) - span);
  endfunction : bp_protects

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic              sclk_rise;
  logic              cs_fall;
  logic              cs_rise;
  logic [2:0]        nib;
  logic [7:0]        sh;
  logic [2:0]        nbytes;
  logic [ADDR_W-1:0] cmd_addr;
  logic              prot;

  always_comb begin
    next_s = s;
    next_s.erase_stb = 1'b0;
    next_s.prog_stb  = 1'b0;
    next_s.buf_we    = 1'b0;
    next_s.buf_clr   = 1'b0;
    next_s.prev_sclk = sy_sclk;
    next_s.prev_cs   = ~sy_cs;

    sclk_rise = sy_sclk & ~s.prev_sclk & sy_cs;
    cs_fall   = sy_cs & s.prev_cs;
    cs_rise   = ~sy_cs & ~s.prev_cs;
    nib       = four_line_command_mode ? 3'h4 : 3'h1;
    // Serial bits or nibbles, high first; upper lines unused when single
    sh        = four_line_command_mode ? {s.sh8[3:0], sy_sio} : {s.sh8[6:0], sy_sio[0]};
    nbytes    = wide_address_mode ? ADDR_BYTES_WIDE : ADDR_BYTES_NARROW;
    cmd_addr  = wide_address_mode ? s.ashift[ADDR_W-1:0]
                                  : {extended_address_bit, s.ashift[23:0]};
    prot      = 1'b0;

    // Frame parsing
    if (cs_fall) begin
      next_s.phase     = SFEPE_PH_OPC;
      next_s.bitcnt    = 3'h0;
      next_s.abytes    = 3'h0;
      next_s.have_data = 1'b0;
      next_s.buf_clr   = ~s.busy;
    end else if (sclk_rise) begin
      next_s.sh8    = sh;
      next_s.bitcnt = s.bitcnt + nib;
      if (s.phase == SFEPE_PH_NOARG) begin
        next_s.phase = SFEPE_PH_IGN;
      end else if (next_s.bitcnt == 3'h0) begin
        unique case (s.phase)
          SFEPE_PH_OPC: begin
            next_s.opcode = sh;
            if (sh == half_block_erase_cmd || sh == full_block_erase_cmd ||
                sh == page_write_cmd) begin
              next_s.phase = SFEPE_PH_ADDR;
            end else if (sh == array_erase_cmd || sh == array_erase_alt_cmd ||
                         sh == write_enable_cmd) begin
              next_s.phase = SFEPE_PH_NOARG;
            end else begin
              next_s.phase = SFEPE_PH_IGN;
            end
          end
          SFEPE_PH_ADDR: begin
            next_s.ashift = {s.ashift[23:0], sh};
            next_s.abytes = s.abytes + 3'h1;
            if (s.abytes + 3'h1 == nbytes) begin
              next_s.phase = SFEPE_PH_DATA;
              next_s.widx  = sh;
            end
          end
          SFEPE_PH_DATA: begin
            // Index wraps in the page; later bytes overwrite earlier
            next_s.buf_we    = ~s.busy;
            next_s.buf_widx  = s.widx;
            next_s.buf_wdata = sh;
            next_s.widx      = s.widx + 8'h01;
            next_s.have_data = 1'b1;
          end
          SFEPE_PH_NOARG,
          SFEPE_PH_IGN: begin
            next_s.phase = s.phase;
          end
          default: begin
            next_s.phase = SFEPE_PH_IGN;
          end
        endcase
      end
    end

    // Command acceptance at chip-select rise; ignored while busy
    if (cs_rise && !s.busy && s.bitcnt == 3'h0) begin
      if (s.opcode == write_enable_cmd && s.phase == SFEPE_PH_NOARG) begin
        next_s.latch = 1'b1;
      end else if ((s.opcode == array_erase_cmd || s.opcode == array_erase_alt_cmd) &&
                   s.phase == SFEPE_PH_NOARG && s.latch) begin
        next_s.busy      = 1'b1;
        next_s.op        = SFEPE_OP_CHIP;
        next_s.lock_addr = '0;
        next_s.st        = SFEPE_ST_SCAN;
      end else if ((s.opcode == half_block_erase_cmd ||
                    s.opcode == full_block_erase_cmd) &&
                   s.phase == SFEPE_PH_DATA && !s.have_data && s.latch) begin
        next_s.busy      = 1'b1;
        next_s.op        = (s.opcode == half_block_erase_cmd) ? SFEPE_OP_HALF
                                                              : SFEPE_OP_FULL;
        next_s.taddr     = cmd_addr;
        next_s.lock_addr = cmd_addr[ADDR_W-1:FULL_BLK_LSB];
        next_s.st        = SFEPE_ST_CHECK;
      end else if (s.opcode == page_write_cmd && s.phase == SFEPE_PH_DATA &&
                   s.have_data && s.latch) begin
        next_s.busy      = 1'b1;
        next_s.op        = SFEPE_OP_PAGE;
        next_s.taddr     = cmd_addr;
        next_s.lock_addr = cmd_addr[ADDR_W-1:FULL_BLK_LSB];
        next_s.st        = SFEPE_ST_CHECK;
      end
    end

    // Internal cycle
    unique case (s.st)
      SFEPE_ST_IDLE: begin
        next_s.timer = '0;
      end
      SFEPE_ST_CHECK: begin
        prot = protect_scheme_select ? lock_hit
                                     : bp_protects(s.lock_addr, block_protect_field);
        if (prot) begin
          next_s.busy  = 1'b0;
          next_s.latch = 1'b0;
          next_s.st    = SFEPE_ST_IDLE;
        end else if (s.op == SFEPE_OP_PAGE) begin
          next_s.pidx = 8'h00;
          next_s.st   = SFEPE_ST_PROG;
        end else begin
          next_s.erase_stb  = 1'b1;
          next_s.erase_size = s.op;
          if (s.op == SFEPE_OP_HALF) begin
            next_s.erase_addr = {s.taddr[ADDR_W-1:HALF_BLK_LSB],
                                 HALF_BLK_LSB'(0)};
            next_s.timer      = HALF_CYC;
          end else begin
            next_s.erase_addr = {s.taddr[ADDR_W-1:FULL_BLK_LSB],
                                 FULL_BLK_LSB'(0)};
            next_s.timer      = FULL_CYC;
          end
          next_s.st = SFEPE_ST_TIME;
        end
      end
      SFEPE_ST_SCAN: begin
        if (!protect_scheme_select && block_protect_field != 4'h0) begin
          next_s.busy  = 1'b0;
          next_s.latch = 1'b0;
          next_s.st    = SFEPE_ST_IDLE;
        end else begin
          // Each 64KB block in turn; locked ones are skipped
          if (!(protect_scheme_select && lock_hit)) begin
            next_s.erase_stb  = 1'b1;
            next_s.erase_size = SFEPE_OP_FULL;
            next_s.erase_addr = {s.lock_addr, FULL_BLK_LSB'(0)};
          end
          if (s.lock_addr == LAST_BLK) begin
            next_s.timer = ARRAY_CYC;
            next_s.st    = SFEPE_ST_TIME;
          end else begin
            next_s.lock_addr = s.lock_addr + BLK_W'(1);
          end
        end
      end
      SFEPE_ST_PROG: begin
        // Only received offsets are written; data zeros clear array bits
        if (buf_rvalid) begin
          next_s.prog_stb  = 1'b1;
          next_s.prog_addr = {s.taddr[ADDR_W-1:PAGE_LSB], s.pidx};
          next_s.prog_data = buf_rdata;
        end
        if (s.pidx == 8'hFF) begin
          next_s.timer = PAGE_CYC;
          next_s.st    = SFEPE_ST_TIME;
        end else begin
          next_s.pidx = s.pidx + 8'h01;
        end
      end
      SFEPE_ST_TIME: begin
        if (s.timer == '0) begin
          next_s.busy  = 1'b0;
          next_s.latch = 1'b0;
          next_s.st    = SFEPE_ST_IDLE;
        end else begin
          next_s.timer = s.timer - 32'h1;
        end
      end
      default: begin
        next_s.busy = 1'b0;
        next_s.st   = SFEPE_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s         <= '0;
      s.prev_cs <= 1'b1;
      s.phase   <= SFEPE_PH_IGN;
      s.st      <= SFEPE_ST_IDLE;
      s.op      <= SFEPE_OP_HALF;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign busy_flag          = s.busy;
  assign write_enable_latch = s.latch;
  assign lock_addr          = s.lock_addr;
  assign erase_stb          = s.erase_stb;
  assign erase_addr         = s.erase_addr;
  assign erase_size         = s.erase_size;
  assign prog_stb           = s.prog_stb;
  assign prog_addr          = s.prog_addr;
  assign prog_data          = s.prog_data;

endmodule : sfepe_engine

`default_nettype wire

// *** verification/sfepe_engine_props.sv ***
// Port checker for the erase/program engine.
// Assumes a bind onto sfepe_engine; outputs hold still while clk_en is low.
`default_nettype none

module sfepe_engine_props
  import sfepe_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              cs_n_pin,
  input wire logic              busy_flag,
  input wire logic              write_enable_latch,
  input wire logic              erase_stb,
  input wire logic [ADDR_W-1:0] erase_addr,
  input wire logic [1:0]        erase_size,
  input wire logic              prog_stb,
  input wire logic [ADDR_W-1:0] prog_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_cycle_start;
    $rose(busy_flag);
  endsequence
  sequence s_prog_pair;
    prog_stb ##1 prog_stb;
  endsequence

  a_start_after_frame: assert property (s_cycle_start |-> cs_n_pin && write_enable_latch)
    else $error("busy rose without a closed enabled frame");
  a_end_clears_latch: assert property ($fell(busy_flag) |-> !write_enable_latch)
    else $error("latch survived end of cycle");
  a_erase_in_cycle: assert property (erase_stb |-> busy_flag && write_enable_latch)
    else $error("erase strobe outside an enabled cycle");
  a_prog_in_cycle: assert property (prog_stb |-> busy_flag && !erase_stb)
    else $error("program strobe outside a cycle");
  a_half_align: assert property (erase_stb && erase_size == 2'h0 |-> erase_addr[14:0] == 15'h0)
    else $error("half block erase address not aligned");
  a_full_align: assert property (erase_stb && erase_size != 2'h0
                                 |-> erase_size == 2'h1 && erase_addr[15:0] == 16'h0)
    else $error("full block erase address not aligned");
  a_prog_page_wrap: assert property (s_prog_pair |-> prog_addr[24:8] == $past(prog_addr[24:8])
                                     && prog_addr[7:0] > $past(prog_addr[7:0]))
    else $error("program left its page");
  a_latch_idle_set: assert property ($rose(write_enable_latch) |-> !busy_flag && cs_n_pin)
    else $error("latch set during a cycle or frame");
endmodule : sfepe_engine_props

`default_nettype wire

// *** verification/sfepe_host.sv ***
// Host controller model driving the serial pins of the engine.
// Assumes clk is the engine clock; sclk half period is 4 clocks.
`default_nettype none

module sfepe_host (
  input  wire logic       clk,
  output var  logic       cs_n,
  output var  logic       sclk,
  output var  logic [3:0] sio
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio  = 4'h0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #2;
  endtask : half
  task automatic start();
    half();
    cs_n = 1'b0;
  endtask : start
  task automatic put(input logic [3:0] v);
    sio = v;
    half();
    sclk = 1'b1;
    half();
    sclk = 1'b0;
  endtask : put
  // Upper lines carry junk in single mode; quad is high nibble first
  task automatic send(input logic [7:0] b, input logic q);
    if (q) begin
      put(b[7:4]);
      put(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) put({{3{~b[i]}}, b[i]});
    end
  endtask : send
  // Released lines show the inverse of the last value
  task automatic stop();
    half();
    cs_n = 1'b1;
    sio  = ~sio;
    half();
  endtask : stop
endmodule : sfepe_host

`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the erase/program engine.
// Assumes a host model on the pins and a lock table on lock_hit.
`default_nettype none

module tb
  import sfepe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, clk_en = 1, cs_n, sclk, lock_hit;
  logic [3:0] sio;
  logic four_line_command_mode = 0, wide_address_mode = 0, extended_address_bit = 0;
  logic protect_scheme_select = 0;
  logic [3:0] block_protect_field = 4'h0;
  logic busy_flag, write_enable_latch, erase_stb, prog_stb;
  logic [BLK_W-1:0] lock_addr;
  logic [ADDR_W-1:0] erase_addr, prog_addr, last_ea;
  logic [1:0] erase_size, last_es;
  logic [7:0] prog_data;
  logic [7:0] dat [0:257];
  logic [7:0] pmem [logic [ADDR_W-1:0]];
  int n_mismatch = 0, check_count = 0, n_erase = 0, cyc = 0, seed = 19;

  always #12.5 clk = ~clk;
  // Bottom and top blocks hold locked sectors
  assign lock_hit = (lock_addr == 9'h000) || (&lock_addr);

  sfepe_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sio(sio));
  sfepe_engine #(.HALF_TIME_US(1), .FULL_TIME_US(1), .ARRAY_TIME_US(1), .PAGE_TIME_US(1)) u_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n_pin(cs_n), .sclk_pin(sclk), .sio_pin(sio),
    .four_line_command_mode(four_line_command_mode), .wide_address_mode(wide_address_mode),
    .extended_address_bit(extended_address_bit), .protect_scheme_select(protect_scheme_select),
    .block_protect_field(block_protect_field), .lock_hit(lock_hit), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch), .lock_addr(lock_addr), .erase_stb(erase_stb),
    .erase_addr(erase_addr), .erase_size(erase_size), .prog_stb(prog_stb),
    .prog_addr(prog_addr), .prog_data(prog_data));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    if (erase_stb === 1'b1) begin
      n_erase++;
      last_ea = erase_addr;
      last_es = erase_size;
    end
    if (prog_stb === 1'b1) pmem[prog_addr] = prog_data;
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int nd, input int xb);
    int na;
    na = (op == write_enable_cmd || op == array_erase_cmd || op == array_erase_alt_cmd) ? 0 :
         (wide_address_mode ? 4 : 3);
    u_host.start();
    u_host.send(op, four_line_command_mode);
    for (int i = na - 1; i >= 0; i--) u_host.send(a[8*i +: 8], four_line_command_mode);
    for (int i = 0; i < nd; i++) u_host.send(dat[i], four_line_command_mode);
    repeat (xb) u_host.put(4'h1);
    u_host.stop();
  endtask : cmd

  task automatic run(input logic [7:0] op, input logic [31:0] a, input int nd, input int xb,
                     input bit we);
    int k;
    k = 0;
    if (we) cmd(write_enable_cmd, 0, 0, 0);
    n_erase = 0;
    pmem.delete();
    cmd(op, a, nd, xb);
    repeat (8) @(posedge clk);
    while (busy_flag !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    #2;
    chk("busy_end", 0, busy_flag);
  endtask : run

  initial begin
    logic [31:0] a;
    repeat (20) @(posedge clk);
    #2 rst_n = 1;
    run(full_block_erase_cmd, 32'h10000, 0, 0, 0);
    chk("erase_count", 0, n_erase);
    for (int k = 0; k < 4; k++) begin
      a = $random(seed) & 32'h01FFFFFF;
      four_line_command_mode = k[0];
      extended_address_bit = k[1];
      wide_address_mode = (k == 3);
      run(k[1] ? half_block_erase_cmd : full_block_erase_cmd, a, 0, 0, 1);
      if (k != 3) a[24] = k[1];
      chk("erase_count", 1, n_erase);
      chk("erase_addr", k[1] ? a & 32'h01FF8000 : a & 32'h01FF0000, last_ea);
      chk("erase_size", {31'h0, ~k[1]}, last_es);
      chk("latch_after", 0, write_enable_latch);
    end
    wide_address_mode = 0;
    extended_address_bit = 0;
    four_line_command_mode = 0;
    run(full_block_erase_cmd, 32'h20000, 0, 3, 1);
    chk("erase_count", 0, n_erase);
    chk("latch_kept", 1, write_enable_latch);
    run(half_block_erase_cmd, 32'h20000, 1, 0, 1);
    chk("erase_count", 0, n_erase);
    run(array_erase_cmd, 0, 0, 1, 1);
    chk("erase_count", 0, n_erase);
    block_protect_field = 4'hA;
    run(full_block_erase_cmd, 32'h30000, 0, 0, 1);
    chk("erase_count", 0, n_erase);
    block_protect_field = 4'h1;
    run(array_erase_cmd, 0, 0, 0, 1);
    chk("erase_count", 0, n_erase);
    chk("latch_after", 0, write_enable_latch);
    block_protect_field = 4'h0;
    run(array_erase_cmd, 0, 0, 0, 1);
    chk("erase_count", NUM_BLOCKS, n_erase);
    protect_scheme_select = 1;
    run(array_erase_alt_cmd, 0, 0, 0, 1);
    chk("erase_count", NUM_BLOCKS - 2, n_erase);
    run(full_block_erase_cmd, 32'h00001234, 0, 0, 1);
    chk("erase_count", 0, n_erase);
    protect_scheme_select = 0;
    for (int i = 0; i < 258; i++) dat[i] = $random(seed);
    a = ($random(seed) & 32'h00FFFF00) | 32'hFE;
    run(page_write_cmd, a, 3, 0, 1);
    chk("prog_count", 3, pmem.num());
    for (int i = 0; i < 3; i++) begin
      chk("prog_byte", dat[i], pmem[{a[24:8], 8'(8'hFE + i)}]);
    end
    four_line_command_mode = 1;
    a = a & 32'h00FFFF00;
    run(page_write_cmd, a, 258, 0, 1);
    chk("prog_count", PAGE_BYTES, pmem.num());
    for (int j = 0; j < 256; j++) begin
      chk("prog_byte", dat[j < 2 ? j + 256 : j], pmem[{a[24:8], 8'(j)}]);
    end
    run(page_write_cmd, a, 1, 1, 1);
    chk("prog_count", 0, pmem.num());
    run(page_write_cmd, a, 0, 0, 1);
    chk("prog_count", 0, pmem.num());
    // Frozen clock enable: the frame is never seen, the latch still stands
    clk_en = 0;
    run(full_block_erase_cmd, 32'h40000, 0, 0, 1);
    chk("erase_count", 0, n_erase);
    clk_en = 1;
    run(full_block_erase_cmd, 32'h40000, 0, 0, 0);
    chk("erase_count", 1, n_erase);
    chk("erase_addr", 32'h40000, last_ea);
    end_sim();
  end
endmodule : tb

bind sfepe_engine sfepe_engine_props u_props (
  .clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .busy_flag(busy_flag),
  .write_enable_latch(write_enable_latch), .erase_stb(erase_stb), .erase_addr(erase_addr),
  .erase_size(erase_size), .prog_stb(prog_stb), .prog_addr(prog_addr));

`default_nettype wire
